//--- dv/osd_port_properties.sv
`timescale 1ns/1ps
module osd_port_properties
  import osd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [osd_pkg::APB_AW-1:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic irq_request_out,
  input wire logic [osd_pkg::LINE_W-1:0] line_count_value_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire setup = psel_in && !penable_in;
  wire mapped = paddr_in <= OFF_LINE_COUNT && paddr_in[1:0] == 2'b00;
  wire ro_wr = pwrite_in && paddr_in == OFF_LINE_COUNT;
  property p_rdy; setup |=> pready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  property p_one; pready_out |=> !pready_out; endproperty
  a_one: assert property (p_one) else $error("pready held");
  property p_idle; !pready_out |-> prdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_unm; setup && !mapped |=> pslverr_out && prdata_out == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_ro; setup && ro_wr |=> pslverr_out; endproperty
  a_ro: assert property (p_ro) else $error("count write not refused");
  property p_ok; setup && mapped && !ro_wr |=> !pslverr_out; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without pready");
  property p_cnt;
    $changed(line_count_value_out) |->
      line_count_value_out == 4'h0 || line_count_value_out == $past(line_count_value_out) + 4'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("line count jump");
  property p_irq; irq_request_out |=> !irq_request_out; endproperty
  a_irq: assert property (p_irq) else $error("request longer than one cycle");
  property p_irq_cnt;
    irq_request_out |-> line_count_value_out == 4'h0 || $changed(line_count_value_out);
  endproperty
  a_irq_cnt: assert property (p_irq_cnt) else $error("request without count event");
endmodule // osd_port_properties
bind osd_line_irq_and_memory_port osd_port_properties chk_u (.core_clk_in, .rst_n_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out,
  .irq_request_out, .line_count_value_out);

//--- dv/test_osd_line_irq_and_memory_port.sv
`timescale 1ns/1ps
module test_osd_line_irq_and_memory_port;
  import osd_pkg::*;
  logic core_clk_in, rst_n_in, psel, pen, pwr, rdy, err, irq, vd_n, hd_n, last, serr;
  logic [7:0] pa;
  logic [31:0] pwd, prd, prd_q;
  logic [8:0] vaddr, vcode;
  logic [6:0] vattr;
  logic [3:0] lcnt;
  logic [4:0] ctl [5] = '{5'h1F, 5'h00, 5'h02, 5'h03, 5'h05};
  int ex [5] = '{1, 1, 1, 1, 0};
  int bad_count, checked, irqs;
  osd_line_irq_and_memory_port dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .vertical_drive_pulse_n_in(vd_n), .horizontal_drive_pulse_n_in(hd_n),
    .last_scan_line_in(last), .video_addr_in(vaddr), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .irq_request_out(irq), .line_count_value_out(lcnt),
    .video_code_out(vcode), .video_attr_out(vattr));
  video_timing_model vt_u (.core_clk_in(core_clk_in), .vd_n_out(vd_n), .hd_n_out(hd_n),
    .last_out(last));
  initial
  begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (irq === 1'b1) irqs++;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single-word transfers with an idle cycle between them
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in) psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge core_clk_in) pen <= 1'b1;
    do @(posedge core_clk_in); while (rdy !== 1'b1);
    prd_q = prd;
    serr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(prd_q, e);
  endtask
  task automatic adr(input logic [8:0] v);
    wr(8'h08, {31'h0, v[8]});
    wr(8'h0C, {24'h0, v[7:0]});
  endtask
  task automatic cad(input logic [8:0] v);
    rd(8'h08, {31'h0, v[8]});
    rd(8'h0C, {24'h0, v[7:0]});
  endtask
  task automatic vid(input logic [8:0] a, input logic [8:0] c, input logic [6:0] t);
    vaddr <= a;
    repeat (3) @(posedge core_clk_in);
    cmp({16'h0, vcode, vattr}, {16'h0, c, t});
  endtask
  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    {rst_n_in, psel, pen, pwr, pa, pwd, vaddr} = '0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // Display memory is not reset: give the swept locations known contents
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    adr(9'h000);
    for (int i = 0; i <= 7; i++) rd(8'(4 * i), 32'h0);
    wr(8'h00, 32'h1F);
    rd(8'h00, 32'h1F);
    rd(8'h20, 32'h0);
    cmp(serr, 1'b1);
    wr(8'h1C, 32'h5);
    cmp(serr, 1'b1);
    adr(9'h120);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h20);
    cad(9'h121);
    adr(9'h120);
    wr(8'h18, 32'h01);
    cad(9'h121);
    adr(9'h120);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h20);
    cad(9'h121);
    adr(9'h120);
    rd(8'h18, 32'h01);
    cad(9'h121);
    vid(9'h120, 9'h020, 7'h01);
    wr(8'h04, 32'h2);
    adr(9'h130);
    wr(8'h18, 32'h55);
    cad(9'h130);
    wr(8'h10, 32'h1);
    wr(8'h14, 32'hAB);
    cad(9'h131);
    wr(8'h14, 32'hCD);
    cad(9'h132);
    vid(9'h130, 9'h1AB, 7'h55);
    vid(9'h131, 9'h1CD, 7'h55);
    wr(8'h04, 32'h6);
    adr(9'h130);
    rd(8'h18, 32'h55);
    cad(9'h130);
    rd(8'h10, 32'h1);
    rd(8'h14, 32'hAB);
    cad(9'h131);
    wr(8'h04, 32'h5);
    rd(8'h04, 32'h5);
    adr(9'h130);
    rd(8'h14, 32'hAB);
    rd(8'h18, 32'h55);
    cad(9'h130);
    wr(8'h04, 32'h41);
    rd(8'h04, 32'h41);
    wr(8'h14, 32'h77);
    cad(9'h131);
    wr(8'h18, 32'h2A);
    cad(9'h132);
    vid(9'h130, 9'h177, 7'h55);
    vid(9'h131, 9'h1CD, 7'h2A);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h00, {27'h0, ctl[i]});
      irqs = 0;
      vt_u.frame(3);
      cmp(irqs, ex[i]);
      cmp(lcnt, 4'h3);
      repeat (2) rd(8'h1C, 32'h3);
    end
    rst_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(8'h00, 32'h0);
    cad(9'h000);
    end_sim;
  end
endmodule // test_osd_line_irq_and_memory_port

//--- dv/video_timing_model.sv
`timescale 1ns/1ps
module video_timing_model
(
  input wire logic core_clk_in,
  output logic vd_n_out,
  output logic hd_n_out,
  output logic last_out
);
  initial
  begin
    vd_n_out = 1'b1;
    hd_n_out = 1'b1;
    last_out = 1'b0;
  end
  // One scan line; pulses stay low long enough for the sync stages
  task automatic scan(input logic lst);
    @(posedge core_clk_in) last_out <= lst;
    repeat (8) @(posedge core_clk_in);
    hd_n_out <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    hd_n_out <= 1'b1;
    last_out <= 1'b0;
  endtask
  // Frame of display lines, two scan lines each
  task automatic frame(input int lines);
    @(posedge core_clk_in) vd_n_out <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    vd_n_out <= 1'b1;
    for (int i = 0; i < 2 * lines; i++) scan(i[0]);
    repeat (8) @(posedge core_clk_in);
  endtask
endmodule // video_timing_model

//--- logic/osd_line_irq_and_memory_port.sv
// What this block does
// RL1: Vertical drive fall clears 4-bit line counter
// RL2: Line-ending horizontal drive fall advances counter
// RL3: Software reads unsynchronised counter several times
// RL4: Source select picks compare match or vertical
// RL5: Compare zero fires on clear, n on line
// RL6: Nine-bit address selects display memory location
// RL7: Nine-bit code and seven-bit attribute data registers
// RL8: Bank select: separate or combined code/attribute access
// RL9: Register writes take effect at once
// RL10: Software writes only undisplayed memory locations
// RL11: Software uses single-byte transfers only
// RL12: Software spaces address and data accesses
// RL13: Software writes address high bit, then low
// RL14: Normal mode auto-increments after code low and separate attribute accesses
// RL15: Software sets mode bits per access kind
// RL16: Code low write commits nine bits, increments
// RL17: Separate attribute write commits and increments
// RL18: Combined attribute write commits and holds address; code commit increments
// RL19: Separate-kind normal-mode reads increment after code low/attribute
// RL20: Combined read increments only after code low
// RL21: Modify mode reads keep address, writes increment
// RL22: Unwritten code high bit keeps old value
// RL23: One synchronised request pulse per event
`timescale 1ns/1ps
module osd_line_irq_and_memory_port
  import osd_pkg::*;
#(
  parameter int MEM_DEPTH = osd_pkg::MEM_DEPTH_DEFAULT
)
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic vertical_drive_pulse_n_in,
  input wire logic horizontal_drive_pulse_n_in,
  input wire logic last_scan_line_in,
  input wire logic [osd_pkg::ADDR_W-1:0] video_addr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [osd_pkg::APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_request_out,
  output logic [osd_pkg::LINE_W-1:0] line_count_value_out,
  output logic [osd_pkg::CODE_W-1:0] video_code_out,
  output logic [osd_pkg::ATTR_W-1:0] video_attr_out
);
  import osd_pkg::*;

  function automatic logic hit(input logic [APB_AW-1:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Control and data registers
  logic [3:0] irq_line_compare_reg;
  logic irq_source_select_reg;
  logic [7:0] misc_control_reg;
  logic [ADDR_W-1:0] mem_location_bits_reg;
  logic code_high_reg;
  logic [ATTR_W-1:0] char_attr_reg;
  logic [LINE_W-1:0] line_count_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [CODE_W-1:0] video_code_reg;
  logic [ATTR_W-1:0] video_attr_reg;

  // Display memory in flip-flops
  logic [CODE_W-1:0] mem_code [MEM_DEPTH];
  logic [ATTR_W-1:0] mem_attr [MEM_DEPTH];

  // Sync pin edges
  logic vd_fall;
  logic hd_fall;

  sync_fall_detect u_vd_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(vertical_drive_pulse_n_in),
    .fall_out(vd_fall)
  );

  sync_fall_detect u_hd_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(horizontal_drive_pulse_n_in),
    .fall_out(hd_fall)
  );

  // Line counter and interrupt generator
  wire line_advance = hd_fall & last_scan_line_in & ~vd_fall;
  wire [LINE_W-1:0] line_plus_one = line_count_reg + 4'h1;
  wire compare_zero = (irq_line_compare_reg == 4'h0);
  wire [LINE_W-1:0] line_count_next = vd_fall ? RST_LINE_COUNT :
                                       (line_advance ? line_plus_one : line_count_reg);
  wire irq_on_vertical = vd_fall & (irq_source_select_reg | compare_zero);
  wire irq_on_line = line_advance & ~irq_source_select_reg & ~compare_zero &
                     (line_plus_one == irq_line_compare_reg);
  wire irq_next = irq_on_vertical | irq_on_line;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      line_count_reg <= RST_LINE_COUNT;
    end
    else
    begin
      line_count_reg <= line_count_next; // [RL1] [RL2]
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next; // [RL4] [RL5] [RL23]
    end
  end

  // Bus phases
  wire setup_phase = psel_in & ~penable_in;
  wire access_done = psel_in & penable_in & pready_reg;
  wire bus_write = access_done & pwrite_in;
  wire bus_read = access_done & ~pwrite_in;

  // Address decode
  wire sel_irq = hit(paddr_in, OFF_IRQ_CONTROL);
  wire sel_misc = hit(paddr_in, OFF_MISC_CONTROL);
  wire sel_addr_hi = hit(paddr_in, OFF_ADDR_HIGH);
  wire sel_addr_lo = hit(paddr_in, OFF_ADDR_LOW);
  wire sel_code_hi = hit(paddr_in, OFF_CODE_HIGH);
  wire sel_code_lo = hit(paddr_in, OFF_CODE_LOW);
  wire sel_attr = hit(paddr_in, OFF_CHAR_ATTR);
  wire sel_line = hit(paddr_in, OFF_LINE_COUNT);
  wire sel_mapped = sel_irq | sel_misc | sel_addr_hi | sel_addr_lo |
                    sel_code_hi | sel_code_lo | sel_attr | sel_line;
  // Line count is read-only
  wire bad_access = ~sel_mapped | (sel_line & pwrite_in);

  wire modify_mode = misc_control_reg[MODIFY_MODE_BIT];
  wire bank_select = misc_control_reg[BANK_SELECT_BIT];

  wire wr_irq = bus_write & sel_irq;
  wire wr_misc = bus_write & sel_misc;
  wire wr_addr_hi = bus_write & sel_addr_hi;
  wire wr_addr_lo = bus_write & sel_addr_lo;
  wire wr_code_hi = bus_write & sel_code_hi;
  wire wr_code_lo = bus_write & sel_code_lo;
  wire wr_attr = bus_write & sel_attr;
  wire rd_code_lo = bus_read & sel_code_lo;
  wire rd_attr = bus_read & sel_attr;

  // Address increment after data access
  wire inc_on_write = wr_code_lo | (wr_attr & ~bank_select); // [RL16] [RL17] [RL18]
  wire inc_on_read = ~modify_mode & (rd_code_lo | (rd_attr & ~bank_select)); // [RL19] [RL20] [RL21]
  wire addr_inc = inc_on_write | inc_on_read; // [RL14]
  wire [ADDR_W-1:0] addr_plus_one = mem_location_bits_reg + 9'h001;
  wire [ADDR_W-1:0] addr_next = wr_addr_hi ? {pwdata_in[0], mem_location_bits_reg[7:0]} :
                                wr_addr_lo ? {mem_location_bits_reg[8], pwdata_in[7:0]} :
                                addr_inc ? addr_plus_one : mem_location_bits_reg; // [RL6]

  wire [CODE_W-1:0] code_commit = {code_high_reg, pwdata_in[7:0]}; // [RL22]
  wire [ATTR_W-1:0] attr_write = pwdata_in[ATTR_W-1:0];

  // Read data selection
  wire [CODE_W-1:0] cur_code = mem_code[mem_location_bits_reg];
  wire [ATTR_W-1:0] cur_attr = mem_attr[mem_location_bits_reg];
  wire [31:0] irq_view = {27'h0000000, irq_source_select_reg, irq_line_compare_reg};
  wire [31:0] rd_value =
    sel_irq ? irq_view :
    sel_misc ? {24'h000000, misc_control_reg} :
    sel_addr_hi ? {31'h00000000, mem_location_bits_reg[8]} :
    sel_addr_lo ? {24'h000000, mem_location_bits_reg[7:0]} :
    sel_code_hi ? {31'h00000000, cur_code[8]} :
    sel_code_lo ? {24'h000000, cur_code[7:0]} :
    sel_attr ? {25'h0000000, cur_attr} :
    sel_line ? {28'h0000000, line_count_reg} : // [RL3]
    32'h0000_0000;

  // Bus slave answers in the cycle after setup
  wire pready_next = setup_phase;
  wire pslverr_next = setup_phase & bad_access;
  wire [31:0] prdata_next = (setup_phase & ~pwrite_in) ? rd_value : RST_PRDATA;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= pready_next; // [RL9]
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pslverr_reg <= pslverr_next;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      prdata_reg <= RST_PRDATA;
    end
    else
    begin
      prdata_reg <= prdata_next;
    end
  end

  // Control registers steer logic from the next cycle on
  wire [3:0] irq_line_compare_next = wr_irq ? pwdata_in[IRQ_COMPARE_LSB+3:IRQ_COMPARE_LSB] :
                                     irq_line_compare_reg;
  wire irq_source_select_next = wr_irq ? pwdata_in[IRQ_SOURCE_BIT] : irq_source_select_reg;
  wire [7:0] misc_control_next = wr_misc ? pwdata_in[7:0] : misc_control_reg;
  wire code_high_next = wr_code_hi ? pwdata_in[0] : code_high_reg;
  wire [ATTR_W-1:0] char_attr_next = wr_attr ? attr_write : char_attr_reg;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_line_compare_reg <= RST_IRQ_COMPARE;
      irq_source_select_reg <= RST_IRQ_SOURCE;
    end
    else
    begin
      irq_line_compare_reg <= irq_line_compare_next; // [RL9]
      irq_source_select_reg <= irq_source_select_next; // [RL4]
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      misc_control_reg <= RST_MISC_CONTROL;
    end
    else
    begin
      misc_control_reg <= misc_control_next; // [RL8] [RL9]
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      mem_location_bits_reg <= RST_ADDRESS;
    end
    else
    begin
      mem_location_bits_reg <= addr_next;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      code_high_reg <= RST_CODE_HIGH;
    end
    else
    begin
      code_high_reg <= code_high_next; // [RL7]
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      char_attr_reg <= RST_ATTR;
    end
    else
    begin
      char_attr_reg <= char_attr_next; // [RL7]
    end
  end

  // Memory commits
  always_ff @(posedge core_clk_in)
  begin
    if (wr_code_lo)
    begin
      mem_code[mem_location_bits_reg] <= code_commit; // [RL16]
      if (bank_select)
      begin
        mem_attr[mem_location_bits_reg] <= char_attr_reg; // [RL18]
      end
    end
    if (wr_attr)
    begin
      mem_attr[mem_location_bits_reg] <= attr_write; // [RL17] [RL9]
    end
  end

  // Display-side fetch port
  wire [CODE_W-1:0] video_code_next = mem_code[video_addr_in];
  wire [ATTR_W-1:0] video_attr_next = mem_attr[video_addr_in];

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      video_code_reg <= RST_VIDEO_CODE;
    end
    else
    begin
      video_code_reg <= video_code_next;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      video_attr_reg <= RST_ATTR;
    end
    else
    begin
      video_attr_reg <= video_attr_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign irq_request_out = irq_reg;
  assign line_count_value_out = line_count_reg;
  assign video_code_out = video_code_reg;
  assign video_attr_out = video_attr_reg;
endmodule // osd_line_irq_and_memory_port

//--- logic/osd_pkg.sv
package osd_pkg;
  // Geometry
  localparam int ADDR_W = 9;
  localparam int CODE_W = 9;
  localparam int ATTR_W = 7;
  localparam int LINE_W = 4;
  localparam int MEM_DEPTH_DEFAULT = 512;
  localparam int APB_AW = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MISC_CONTROL = 8'h04;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h0C;
  localparam logic [7:0] OFF_CODE_HIGH = 8'h10;
  localparam logic [7:0] OFF_CODE_LOW = 8'h14;
  localparam logic [7:0] OFF_CHAR_ATTR = 8'h18;
  localparam logic [7:0] OFF_LINE_COUNT = 8'h1C;

  // osd_irq_control fields
  localparam int IRQ_COMPARE_LSB = 0;
  localparam int IRQ_SOURCE_BIT = 4;
  // osd_misc_control fields
  localparam int MODIFY_MODE_BIT = 0;
  localparam int BANK_SELECT_BIT = 1;
  localparam int READ_WRITE_BIT = 2;
  localparam int INTENSITY_PIN_BIT = 6;
  // display_mem_char_attr fields
  localparam int ATTR_BLUE_BIT = 0;
  localparam int ATTR_GREEN_BIT = 1;
  localparam int ATTR_RED_BIT = 2;
  localparam int ATTR_INTENSITY_BIT = 3;
  localparam int ATTR_BLINK_BIT = 4;
  localparam int ATTR_UNDERLINE_BIT = 5;
  localparam int ATTR_SLANT_BIT = 6;

  // Reset values
  localparam logic [3:0] RST_IRQ_COMPARE = 4'h0;
  localparam logic RST_IRQ_SOURCE = 1'b0;
  localparam logic [7:0] RST_MISC_CONTROL = 8'h00;
  localparam logic [8:0] RST_ADDRESS = 9'h000;
  localparam logic RST_CODE_HIGH = 1'b0;
  localparam logic [6:0] RST_ATTR = 7'h00;
  localparam logic [8:0] RST_VIDEO_CODE = 9'h000;
  localparam logic [3:0] RST_LINE_COUNT = 4'h0;
  localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

  // Synchroniser depth in flip-flops
  localparam int SYNC_STAGES = 2;
endpackage

//--- logic/sync_fall_detect.sv
`timescale 1ns/1ps
module sync_fall_detect
  import osd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic fall_out
);
  logic [SYNC_STAGES-1:0] sync_reg;
  logic last_reg;
  logic fall_reg;
  // Idle level of the active-low sync pins is high
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      sync_reg <= {SYNC_STAGES{1'b1}};
      last_reg <= 1'b1;
      fall_reg <= 1'b0;
    end
    else
    begin
      sync_reg <= {sync_reg[SYNC_STAGES-2:0], pin_in};
      last_reg <= sync_reg[SYNC_STAGES-1];
      fall_reg <= last_reg & ~sync_reg[SYNC_STAGES-1];
    end
  end
  assign fall_out = fall_reg;
endmodule // sync_fall_detect
